// File: src/dsmc_pkg.sv
// Package: register map, field layout, reset values and baud divisor
`default_nettype none
package dsmc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_CLK_A = 4'h7;
  localparam logic [3:0] IDX_FRQ_HI = 4'h8;
  localparam logic [3:0] IDX_FRQ_MID = 4'h9;
  localparam logic [3:0] IDX_FRQ_LO = 4'hA;
  localparam logic [3:0] IDX_CLK_B = 4'hB;
  localparam logic [3:0] IDX_OSC = 4'hC;
  // Clock divider register fields
  localparam int REF_DIV_MSB = 7;
  localparam int REF_DIV_LSB = 5;
  localparam int MDIV1_MSB = 4;
  localparam int MDIV1_LSB = 2;
  localparam int MDIV2_MSB = 1;
  localparam int MDIV2_LSB = 0;
  // Oscillator current fields, then the dither bit of the low word B register
  localparam int OSC_A_MSB = 7;
  localparam int OSC_A_LSB = 4;
  localparam int OSC_B_MSB = 3;
  localparam int OSC_B_LSB = 0;
  localparam int DITHER_BIT = 0;
  // Reset values: ref code 2, first divider code 4, second divider code 0
  localparam logic [7:0] RST_CLK = 8'h50;
  localparam logic [7:0] RST_FRQ_HI = 8'h83;
  localparam logic [7:0] RST_FRQ_MID = 8'hBD;
  localparam logic [7:0] RST_FRQ_LO = 8'hF9;
  localparam logic [7:0] RST_OSC = 8'h88;
  // Baud enable fires when the modem pulse count equals this, so it is the modem clock divided by eight
  localparam logic [2:0] BAUD_DIV = 3'h7;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// File: src/dsmc_frac_div.sv
// Half-cycle-accurate divider: pulses at ratio (num/2) of input enables
`default_nettype none
module dsmc_frac_div #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Rate control: ratio is i_half/2 input pulses, i_half at least 4
  input wire logic i_en,
  input wire logic [W-1:0] i_half,
  // Output enable pulse
  output logic o_pulse
);
  typedef struct packed {
    logic [W-1:0] acc;
    logic pulse;
  } dsmc_fd_s;
  dsmc_fd_s q, d;

  // Accumulate 2 per input, emit when reaching the half count; keeps fractional ratios exact
  always_comb begin
    logic [W-1:0] rem;
    rem = q.acc + W'(2) - i_half;
    d = q;
    d.pulse = 1'b0;
    if (i_en) begin
      if (q.acc + W'(2) >= i_half) begin
        // After a ratio drop, restart instead of bursting back-to-back pulses
        d.acc = (rem + W'(2) >= i_half) ? '0 : rem;
        d.pulse = 1'b1;
      end else begin
        d.acc = q.acc + W'(2);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_pulse = q.pulse;
endmodule
`default_nettype wire

// File: src/dsmc_rate_gen.sv
// Reference, modem and baud enable chain for one divider setting
`default_nettype none
module dsmc_rate_gen (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Divider setting
  input wire logic [2:0] i_ref_div,
  input wire logic [2:0] i_mdiv1,
  input wire logic [1:0] i_mdiv2,
  // Enable pulses
  output logic o_ref_en,
  output logic o_modem_en,
  output logic o_baud_en
);
  logic [7:0] ref_half;
  logic [7:0] m1_half;
  logic m1_en;
  typedef struct packed {
    logic [6:0] m2_cnt;
    logic [2:0] baud_cnt;
    logic modem;
    logic baud;
  } dsmc_rg_s;
  dsmc_rg_s q, d;

  // Code n divides by n+1; code 0 is unsupported and treated as code 1
  assign ref_half = (i_ref_div == 3'h0) ? 8'h04 : {4'h0, i_ref_div, 1'b0} + 8'h02; // [R01] [R02]

  // First divider ratios in half steps
  always_comb begin
    unique case (i_mdiv1) // [R03]
      3'h0: m1_half = 8'h05;
      3'h1: m1_half = 8'h06;
      3'h2: m1_half = 8'h08;
      3'h3: m1_half = 8'h0F;
      3'h4: m1_half = 8'h19;
      3'h5: m1_half = 8'h50;
      3'h6: m1_half = 8'h60;
      3'h7: m1_half = 8'h80;
    endcase
  end

  dsmc_frac_div #(.W(8)) u_ref (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_en(1'b1),
    .i_half(ref_half),
    .o_pulse(o_ref_en)
  );

  // Modem clock is reference over the product of both ratios
  dsmc_frac_div #(.W(8)) u_m1 (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_en(o_ref_en),
    .i_half(m1_half),
    .o_pulse(m1_en)
  ); // [R05]

  always_comb begin
    d = q;
    d.modem = 1'b0;
    d.baud = 1'b0;
    if (m1_en) begin
      if (q.m2_cnt >= (7'h01 << i_mdiv2) - 7'h01) begin // [R04] [R05]
        d.m2_cnt = '0;
        d.modem = 1'b1;
      end else begin
        d.m2_cnt = q.m2_cnt + 7'h01;
      end
    end
    if (q.modem) begin
      d.baud_cnt = q.baud_cnt + 3'h1;
      d.baud = (q.baud_cnt == dsmc_pkg::BAUD_DIV); // [R06]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_modem_en = q.modem;
  assign o_baud_en = q.baud;
endmodule
`default_nettype wire

// File: src/dsmc_top.sv
// Dual-set modem clock configuration with AXI4-Lite register access
//
// Contract
// [R01] Reference divisor code 1 divides crystal by 2, code 7 by 8; 0 unsupported.
// [R02] Reference codes 2 to 6 divide the crystal by code plus one.
// [R03] First modem divider codes 0..7 give 2.5,3,4,7.5,12.5,40,48,64.
// [R04] Second modem divider codes 0..3 give 1,2,4,8.
// [R05] Modem clock is reference over product of both modem divider ratios.
// [R06] Baud rate is one eighth of the modem clock.
// [R07] Set B keeps its own independent dividers with set A encodings.
// [R08] Word B: bits 22:15, 14:7, and 6:0 in upper bits of third register.
// [R09] Low word B register bit 0 enables dithering for set B, default one.
// [R10] Oscillator register upper nibble is set A core current, default 8.
// [R11] Oscillator register lower nibble is set B core current, same steps.
// [R12] Software prefers the smallest reference divisor reaching the desired baud.
`default_nettype none
module dsmc_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // AXI4-Lite write address
  input wire logic i_awvalid,
  input wire logic [31:0] i_awaddr,
  output logic o_awready,
  // AXI4-Lite write data
  input wire logic i_wvalid,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_wready,
  // AXI4-Lite write response
  output logic o_bvalid,
  output logic [1:0] o_bresp,
  input wire logic i_bready,
  // AXI4-Lite read address
  input wire logic i_arvalid,
  input wire logic [31:0] i_araddr,
  output logic o_arready,
  // AXI4-Lite read data
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_rready,
  // Configuration outputs
  output logic [22:0] o_synth_word_b,
  output logic o_synth_dither_enable_b,
  output logic [3:0] o_osc_core_current_a,
  output logic [3:0] o_osc_core_current_b,
  // Rate enables, set A then set B
  output logic o_ref_en_a,
  output logic o_modem_en_a,
  output logic o_baud_en_a,
  output logic o_ref_en_b,
  output logic o_modem_en_b,
  output logic o_baud_en_b
);
  typedef struct packed {
    logic [7:0] clk_a;
    logic [7:0] frq_hi;
    logic [7:0] frq_mid;
    logic [7:0] frq_lo;
    logic [7:0] clk_b;
    logic [7:0] osc;
    logic aw_got;
    logic [31:0] awaddr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [5:0] ens;
  } dsmc_regs_s;
  dsmc_regs_s q, d;

  logic ref_a, modem_a, baud_a, ref_b, modem_b, baud_b;

  // Decode a word address to a register index; unmapped gives a miss
  function automatic logic [4:0] dsmc_idx(input logic [31:0] a);
    logic [4:0] r;
    r = 5'h10;
    if (a[31:6] == '0 && a[1:0] == 2'h0) begin
      unique case (a[5:2])
        dsmc_pkg::IDX_CLK_A, dsmc_pkg::IDX_FRQ_HI, dsmc_pkg::IDX_FRQ_MID,
        dsmc_pkg::IDX_FRQ_LO, dsmc_pkg::IDX_CLK_B, dsmc_pkg::IDX_OSC: r = {1'b0, a[5:2]};
        default: r = 5'h10;
      endcase
    end
    return r;
  endfunction

  always_comb begin
    logic [4:0] widx;
    logic [4:0] ridx;
    logic [7:0] rv;
    d = q;
    widx = dsmc_idx(q.awaddr);
    ridx = dsmc_idx(i_araddr);
    rv = 8'h00;
    // Enables re-registered so every rate enable output is a flop
    d.ens = {ref_a, modem_a, baud_a, ref_b, modem_b, baud_b};
    // Write channels accepted independently, in either order
    if (i_awvalid && !q.aw_got) begin
      d.aw_got = 1'b1;
      d.awaddr = i_awaddr;
    end
    if (i_wvalid && !q.w_got) begin
      d.w_got = 1'b1;
      d.wdata = i_wdata[7:0];
      d.wstrb0 = i_wstrb[0];
    end
    if (q.bvalid && i_bready) begin
      d.bvalid = 1'b0;
    end
    // Commit once both halves held and no response pending
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = widx[4] ? dsmc_pkg::RESP_SLVERR : dsmc_pkg::RESP_OKAY;
      if (q.wstrb0 && !widx[4]) begin
        unique case (widx[3:0])
          dsmc_pkg::IDX_CLK_A: d.clk_a = q.wdata;
          dsmc_pkg::IDX_FRQ_HI: d.frq_hi = q.wdata; // [R08]
          dsmc_pkg::IDX_FRQ_MID: d.frq_mid = q.wdata; // [R08]
          dsmc_pkg::IDX_FRQ_LO: d.frq_lo = q.wdata; // [R08] [R09]
          dsmc_pkg::IDX_CLK_B: d.clk_b = q.wdata; // [R07]
          dsmc_pkg::IDX_OSC: d.osc = q.wdata; // [R10] [R11]
          default: d.osc = q.osc;
        endcase
      end
    end
    // Read: one outstanding, answered the cycle after address acceptance
    if (q.rvalid && i_rready) begin
      d.rvalid = 1'b0;
    end
    if (i_arvalid && !q.rvalid) begin
      unique case (ridx[3:0])
        dsmc_pkg::IDX_CLK_A: rv = q.clk_a;
        dsmc_pkg::IDX_FRQ_HI: rv = q.frq_hi;
        dsmc_pkg::IDX_FRQ_MID: rv = q.frq_mid;
        dsmc_pkg::IDX_FRQ_LO: rv = q.frq_lo;
        dsmc_pkg::IDX_CLK_B: rv = q.clk_b;
        dsmc_pkg::IDX_OSC: rv = q.osc;
        default: rv = 8'h00;
      endcase
      if (ridx[4]) begin
        rv = 8'h00;
      end
      d.rvalid = 1'b1;
      d.rdata = {24'h000000, rv};
      d.rresp = ridx[4] ? dsmc_pkg::RESP_SLVERR : dsmc_pkg::RESP_OKAY;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
      q.clk_a <= dsmc_pkg::RST_CLK;
      q.frq_hi <= dsmc_pkg::RST_FRQ_HI;
      q.frq_mid <= dsmc_pkg::RST_FRQ_MID;
      q.frq_lo <= dsmc_pkg::RST_FRQ_LO;
      q.clk_b <= dsmc_pkg::RST_CLK;
      q.osc <= dsmc_pkg::RST_OSC;
    end else begin
      q <= d;
    end
  end

  // Two independent chains, one per setting
  dsmc_rate_gen u_set_a (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ref_div(q.clk_a[dsmc_pkg::REF_DIV_MSB:dsmc_pkg::REF_DIV_LSB]), // [R01]
    .i_mdiv1(q.clk_a[dsmc_pkg::MDIV1_MSB:dsmc_pkg::MDIV1_LSB]), // [R03]
    .i_mdiv2(q.clk_a[dsmc_pkg::MDIV2_MSB:dsmc_pkg::MDIV2_LSB]), // [R04]
    .o_ref_en(ref_a),
    .o_modem_en(modem_a),
    .o_baud_en(baud_a)
  );

  dsmc_rate_gen u_set_b (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ref_div(q.clk_b[dsmc_pkg::REF_DIV_MSB:dsmc_pkg::REF_DIV_LSB]), // [R07]
    .i_mdiv1(q.clk_b[dsmc_pkg::MDIV1_MSB:dsmc_pkg::MDIV1_LSB]), // [R07]
    .i_mdiv2(q.clk_b[dsmc_pkg::MDIV2_MSB:dsmc_pkg::MDIV2_LSB]), // [R07]
    .o_ref_en(ref_b),
    .o_modem_en(modem_b),
    .o_baud_en(baud_b)
  );

  assign o_awready = !q.aw_got;
  assign o_wready = !q.w_got;
  assign o_bvalid = q.bvalid;
  assign o_bresp = q.bresp;
  assign o_arready = !q.rvalid;
  assign o_rvalid = q.rvalid;
  assign o_rdata = q.rdata;
  assign o_rresp = q.rresp;
  assign o_synth_word_b = {q.frq_hi, q.frq_mid, q.frq_lo[7:1]}; // [R08]
  assign o_synth_dither_enable_b = q.frq_lo[dsmc_pkg::DITHER_BIT]; // [R09]
  assign o_osc_core_current_a = q.osc[dsmc_pkg::OSC_A_MSB:dsmc_pkg::OSC_A_LSB]; // [R10]
  assign o_osc_core_current_b = q.osc[dsmc_pkg::OSC_B_MSB:dsmc_pkg::OSC_B_LSB]; // [R11]
  assign o_ref_en_a = q.ens[5];
  assign o_modem_en_a = q.ens[4];
  assign o_baud_en_a = q.ens[3];
  assign o_ref_en_b = q.ens[2];
  assign o_modem_en_b = q.ens[1];
  assign o_baud_en_b = q.ens[0];
endmodule
`default_nettype wire

// File: bench/dsmc_top_properties.sv
// Port-level properties of the modem clock configuration block
`default_nettype none
module dsmc_top_properties (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register bus
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic i_rready,
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic i_bready,
  // Configuration and rates
  input wire logic [22:0] o_synth_word_b,
  input wire logic o_synth_dither_enable_b,
  input wire logic [3:0] o_osc_core_current_a,
  input wire logic [3:0] o_osc_core_current_b,
  input wire logic o_ref_en_a,
  input wire logic o_modem_en_b,
  input wire logic o_baud_en_a
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  chk_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  chk_ar_latency: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  chk_ar_refuse: assert property (o_rvalid |-> !o_arready)
    else $error("read address taken while busy");
  chk_rdata_upper: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_bresp_code: assert property (o_bvalid |->
    (o_bresp == dsmc_pkg::RESP_OKAY) || (o_bresp == dsmc_pkg::RESP_SLVERR))
    else $error("bad write response code");
  // Config only moves as a consequence of a committed write
  chk_cfg_commit: assert property ($changed({o_synth_word_b, o_synth_dither_enable_b,
    o_osc_core_current_a, o_osc_core_current_b}) |-> o_bvalid || $past(o_bvalid))
    else $error("config changed without a write");
  chk_ref_gap: assert property (o_ref_en_a |=> !o_ref_en_a)
    else $error("reference enable too fast");
  chk_modem_gap: assert property (o_modem_en_b |=> !o_modem_en_b)
    else $error("modem enable too fast");
  chk_baud_gap: assert property (o_baud_en_a |=> !o_baud_en_a [*8])
    else $error("baud enable too fast");
endmodule
`default_nettype wire

// File: bench/dsmc_top_tb_top.sv
// Self-checking bench for the dual-set modem clock configuration block
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module dsmc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_rst = 1;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0;
  logic [3:0] i_wstrb = 4'h0, strb = 4'hF;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_synth_dither_enable_b;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata, rd;
  logic [22:0] o_synth_word_b;
  logic [3:0] o_osc_core_current_a, o_osc_core_current_b;
  logic o_ref_en_a, o_modem_en_a, o_baud_en_a, o_ref_en_b, o_modem_en_b, o_baud_en_b;
  logic [1:0] rs;
  int err_total = 0, checks = 0, cyc = 0, m, lag = 0;
  // Half-step ratios of the first modem divider
  int half_t [8] = '{5, 6, 8, 15, 25, 80, 96, 128};
  logic [7:0] def_t [6] = '{8'h50, 8'h83, 8'hBD, 8'hF9, 8'h50, 8'h88};
  wire logic [5:0] ens = {o_baud_en_b, o_modem_en_b, o_ref_en_b,
    o_baud_en_a, o_modem_en_a, o_ref_en_a};
  dsmc_top dsmc_top_i (.i_clk, .i_rst, .i_awvalid, .i_awaddr, .o_awready, .i_wvalid,
    .i_wdata, .i_wstrb, .o_wready, .o_bvalid, .o_bresp, .i_bready, .i_arvalid, .i_araddr,
    .o_arready, .o_rvalid, .o_rdata, .o_rresp, .i_rready, .o_synth_word_b,
    .o_synth_dither_enable_b, .o_osc_core_current_a, .o_osc_core_current_b, .o_ref_en_a,
    .o_modem_en_a, .o_baud_en_a, .o_ref_en_b, .o_modem_en_b, .o_baud_en_b);
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  // Hang guard well above the longest rate sweep
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      complete_run();
    end
  end
  function automatic logic [31:0] adr(input logic [3:0] idx);
    return {26'h0, idx, 2'h0};
  endfunction
  task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_p, w_p;
    aw_p = 1;
    w_p = 1;
    i_awaddr <= a;
    i_wdata <= {24'h0, d};
    i_wstrb <= strb;
    i_awvalid <= 1;
    i_wvalid <= 1;
    while (aw_p || w_p) begin
      @(posedge i_clk);
      if (aw_p && o_awready) begin
        i_awvalid <= 0;
        aw_p = 0;
      end
      if (w_p && o_wready) begin
        i_wvalid <= 0;
        w_p = 0;
      end
    end
    // A late bready makes the response hold itself
    repeat (lag) @(posedge i_clk);
    i_bready <= 1;
    do @(posedge i_clk); while (o_bvalid !== 1'b1);
    r = o_bresp;
    i_bready <= 0;
    @(posedge i_clk);
  endtask
  task automatic rdr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    i_araddr <= a;
    i_arvalid <= 1;
    do @(posedge i_clk); while (o_arready !== 1'b1);
    i_arvalid <= 0;
    repeat (lag) @(posedge i_clk);
    i_rready <= 1;
    do @(posedge i_clk); while (o_rvalid !== 1'b1);
    d = o_rdata;
    r = o_rresp;
    i_rready <= 0;
    @(posedge i_clk);
  endtask
  // Skips two pulses so a ratio change has settled, then times n periods
  task automatic measure(input int sel, input int n, output int c);
    int k;
    k = 0;
    c = 0;
    while (k < n + 2) begin
      @(posedge i_clk);
      if (k >= 2) c++;
      if (ens[sel] === 1'b1) k++;
    end
  endtask
  task automatic t_reset();
    for (int k = 0; k < 6; k++) begin
      rdr(adr(dsmc_pkg::IDX_CLK_A + 4'(k)), rd, rs);
      `CHK(rd, {24'h0, def_t[k]})
    end
    `CHK(o_synth_word_b, {8'h83, 8'hBD, 7'h7C})
    `CHK({o_synth_dither_enable_b, o_osc_core_current_a}, 5'h18)
  endtask
  task automatic t_word();
    wr(adr(dsmc_pkg::IDX_FRQ_HI), 8'hA5, rs);
    wr(adr(dsmc_pkg::IDX_FRQ_MID), 8'h3C, rs);
    wr(adr(dsmc_pkg::IDX_FRQ_LO), 8'h96, rs);
    wr(adr(dsmc_pkg::IDX_OSC), 8'h4C, rs);
    `CHK(rs, dsmc_pkg::RESP_OKAY)
    repeat (2) @(posedge i_clk);
    `CHK(o_synth_word_b, {8'hA5, 8'h3C, 7'h4B})
    `CHK(o_synth_dither_enable_b, 1'b0)
    `CHK({o_osc_core_current_a, o_osc_core_current_b}, 8'h4C)
    rdr(adr(dsmc_pkg::IDX_FRQ_LO), rd, rs);
    `CHK({rs, rd}, {dsmc_pkg::RESP_OKAY, 32'h96})
  endtask
  task automatic t_unmapped();
    lag = 3;
    wr(32'h34, 8'hFF, rs);
    `CHK(rs, dsmc_pkg::RESP_SLVERR)
    rdr(32'h1D, rd, rs);
    `CHK({rs, rd}, {dsmc_pkg::RESP_SLVERR, 32'h0})
    lag = 0;
    // Lane 0 strobe low must leave the register untouched
    strb = 4'hE;
    wr(adr(dsmc_pkg::IDX_OSC), 8'h11, rs);
    strb = 4'hF;
    `CHK(rs, dsmc_pkg::RESP_OKAY)
    rdr(adr(dsmc_pkg::IDX_OSC), rd, rs);
    `CHK({rs, rd}, {dsmc_pkg::RESP_OKAY, 32'h4C})
  endtask
  task automatic t_rates();
    measure(0, 4, m);
    `CHK(m, 12)
    for (int c = 1; c < 8; c++) begin
      wr(adr(dsmc_pkg::IDX_CLK_B), {3'(c), 3'h2, 2'h0}, rs);
      measure(3, 4, m);
      `CHK(m, 4 * (c + 1))
    end
    measure(0, 4, m);
    `CHK(m, 12)
    for (int c = 0; c < 8; c++) begin
      wr(adr(dsmc_pkg::IDX_CLK_B), {3'h1, 3'(c), 2'h0}, rs);
      measure(4, 2, m);
      `CHK(m, 2 * half_t[c])
    end
    for (int c = 0; c < 4; c++) begin
      wr(adr(dsmc_pkg::IDX_CLK_B), {3'h1, 3'h2, 2'(c)}, rs);
      measure(4, 2, m);
      `CHK(m, 16 << c)
    end
    wr(adr(dsmc_pkg::IDX_CLK_A), 8'h20, rs);
    measure(2, 2, m);
    `CHK(m, 80)
    measure(1, 2, m);
    `CHK(m, 10)
    measure(5, 2, m);
    `CHK(m, 1024)
  endtask
  task automatic complete_run();
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 0;
    @(posedge i_clk);
    t_reset();
    t_word();
    t_unmapped();
    t_rates();
    complete_run();
  end
endmodule
bind dsmc_top dsmc_top_properties dsmc_top_properties_i (.i_clk, .i_rst, .i_arvalid,
  .o_arready, .o_rvalid, .o_rdata, .i_rready, .o_bvalid, .o_bresp, .i_bready,
  .o_synth_word_b, .o_synth_dither_enable_b, .o_osc_core_current_a,
  .o_osc_core_current_b, .o_ref_en_a, .o_modem_en_b, .o_baud_en_a);
`default_nettype wire
